// [pkg/tic_params.svh]
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

// Register addresses on the special function register port
`define TIC_ADDR_CTRL 8'ha1
`define TIC_ADDR_HTH 8'ha2
`define TIC_ADDR_SS 8'ha3
`define TIC_ADDR_MM 8'ha4
`define TIC_ADDR_HH 8'ha5
`define TIC_ADDR_IVAL 8'ha6

// Control register bit positions
`define TIC_BIT_TFH 6
`define TIC_BIT_ITS_HI 5
`define TIC_BIT_ITS_LO 4
`define TIC_BIT_STI 3
`define TIC_BIT_FLAG 2
`define TIC_BIT_INTERVAL_COUNT_ENABLE 1
`define TIC_BIT_TIME_CLOCK_ENABLE 0

// Reset values
`define TIC_RST_COUNT 8'h00
`define TIC_RST_CTRL 8'h00

// Rollover limits
`define TIC_HTH_MAX 8'h7f
`define TIC_SS_MAX 8'h3b
`define TIC_MM_MAX 8'h3b
`define TIC_HH24_MAX 8'h17
`define TIC_HHFULL_MAX 8'hff

// Timing: clock period and sub-second tick period in ns
`define TIC_CLK_NS 4
`define TIC_TICK_NS 7812500
`define TIC_TICK_CYCLES (`TIC_TICK_NS / `TIC_CLK_NS)

`endif

// [pkg/tic_pkg.sv]
`default_nettype none
package tic_pkg;

    // Interval counter timebase, in field order 00..11
    typedef enum logic [1:0] {
        TB_SUB,
        TB_SEC,
        TB_MIN,
        TB_HOUR
    } timebase_t;

    // Whole state of the counter block
    typedef struct packed {
        logic [7:0] hth;   // Sub-second count
        logic [7:0] ss;    // Seconds
        logic [7:0] mm;    // Minutes
        logic [7:0] hh;    // Hours
        logic [7:0] ival;  // Interval compare value
        logic [7:0] icnt;  // Interval counter
        logic twenty_four_hour_format;         // 24-hour format
        timebase_t its;    // Interval timebase select
        logic single_interval_select;         // Single interval select
        logic flag;        // Interval match flag
        logic interval_count_enable;        // Interval count enable
        logic time_clock_enable;        // Time clock enable
        logic [7:0] rdata; // Registered read data
        logic irq;         // Registered interrupt request
    } tic_state_t;

endpackage
`default_nettype wire

// [core/tic_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tic_params.svh"

module tic_prescaler #(
    parameter int unsigned TICK_CYCLES = `TIC_TICK_CYCLES
) (
    input wire logic clock_in, // System clock
    input wire logic rst_in,   // Async reset, active high
    output logic tick_out      // One-cycle pulse every tick period
);
    // Counter width, at least one bit
    localparam int W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

    // Local state record
    typedef struct packed {
        logic [W-1:0] cnt; // Cycle count within period
        logic tick;        // Tick pulse
    } presc_state_t;

    presc_state_t s_r; // Registered state
    presc_state_t s_nxt; // Next state

    // Divider: stands in for the crystal-derived 1/128 s tick
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == LAST) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.tick;
endmodule
`default_nettype wire

// [core/time_interval_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tic_params.svh"

// Operation
// - Flag sets when interval count equals compare
// - Flag stays set until software writes zero
// - Enable bit one starts interval counting
// - Enable bit zero stops and clears counter
// - Clock enable gates all counting
// - Timebase field picks interval counter rate
// - Single mode clears enable on match
// - Repeat mode reloads after each match
// - Flag raises interrupt when enabled
// - Sub-second counts 0..127, carries to seconds
// - Seconds count 0..59, carry to minutes
// - Minutes count 0..59, carry to hours
// - Format bit one: hours count 0..23
// - Format bit zero: hours count 0..255
// - Compare and time registers reset zero
module time_interval_counter #(
    parameter int unsigned TICK_CYCLES = `TIC_TICK_CYCLES
) (
    input wire logic clock_in,            // System clock, 250 MHz
    input wire logic rst_in,              // Async reset, active high
    input wire logic [7:0] sfr_addr_in,   // Register address
    input wire logic sfr_wr_in,           // Write strobe
    input wire logic [7:0] sfr_wdata_in,  // Write data
    input wire logic irq_enable_in,       // Processor interrupt enable
    output logic [7:0] sfr_rdata_out,     // Read data, one cycle late
    output logic interval_irq_out,        // Interrupt request level
    output logic interval_match_flag_out  // Match flag level
);
    tic_pkg::tic_state_t s_r;   // Registered state
    tic_pkg::tic_state_t s_nxt; // Next state

    logic presc_tick; // Raw sub-second tick
    logic ev_sub;     // Gated sub-second event
    logic ev_sec;     // Seconds event
    logic ev_min;     // Minutes event
    logic ev_hr;      // Hours event
    logic it_tick;    // Interval counter tick
    logic match;      // Interval match this cycle
    logic ctrl_wr;    // Write to control register
    logic [7:0] hh_max; // Active hour limit

    // Control reset image, named so its bits can be selected
    localparam logic [7:0] RST_CTRL = `TIC_RST_CTRL;
    // Reset image of the whole state
    localparam tic_pkg::tic_state_t RST_STATE = '{
        hth: `TIC_RST_COUNT,
        ss: `TIC_RST_COUNT,
        mm: `TIC_RST_COUNT,
        hh: `TIC_RST_COUNT,
        ival: `TIC_RST_COUNT,
        icnt: `TIC_RST_COUNT,
        twenty_four_hour_format: RST_CTRL[`TIC_BIT_TFH],
        its: tic_pkg::timebase_t'({RST_CTRL[`TIC_BIT_ITS_HI],
            RST_CTRL[`TIC_BIT_ITS_LO]}),
        single_interval_select: RST_CTRL[`TIC_BIT_STI],
        flag: RST_CTRL[`TIC_BIT_FLAG],
        interval_count_enable: RST_CTRL[`TIC_BIT_INTERVAL_COUNT_ENABLE],
        time_clock_enable: RST_CTRL[`TIC_BIT_TIME_CLOCK_ENABLE],
        rdata: 8'h00,
        irq: 1'b0
    };

    // Wrapping increment shared by all time counters
    function automatic logic [7:0] inc_wrap(
        input logic [7:0] val,
        input logic [7:0] max
    );
        inc_wrap = (val >= max) ? 8'h00 : val + 8'h01;
    endfunction

    // Sub-second tick source
    tic_prescaler #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_presc (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .tick_out(presc_tick)
    );

    // Event cascade and interval match decode
    always_comb begin
        ev_sub = presc_tick & s_r.time_clock_enable;
        ev_sec = ev_sub && (s_r.hth == `TIC_HTH_MAX);
        ev_min = ev_sec && (s_r.ss == `TIC_SS_MAX);
        ev_hr = ev_min && (s_r.mm == `TIC_MM_MAX);
        hh_max = s_r.twenty_four_hour_format ? `TIC_HH24_MAX : `TIC_HHFULL_MAX;
        // Timebase choice
        unique case (s_r.its)
            tic_pkg::TB_SUB: it_tick = ev_sub;
            tic_pkg::TB_SEC: it_tick = ev_sec;
            tic_pkg::TB_MIN: it_tick = ev_min;
            tic_pkg::TB_HOUR: it_tick = ev_hr;
        endcase
        it_tick = it_tick & s_r.interval_count_enable;
        match = it_tick && (s_r.icnt == s_r.ival);
        ctrl_wr = sfr_wr_in && (sfr_addr_in == `TIC_ADDR_CTRL);
    end

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        // Time-of-day cascade
        if (ev_sub) begin
            s_nxt.hth = inc_wrap(s_r.hth, `TIC_HTH_MAX);
        end
        if (ev_sec) begin
            s_nxt.ss = inc_wrap(s_r.ss, `TIC_SS_MAX);
        end
        if (ev_min) begin
            s_nxt.mm = inc_wrap(s_r.mm, `TIC_MM_MAX);
        end
        if (ev_hr) begin
            s_nxt.hh = inc_wrap(s_r.hh, hh_max);
        end
        // Interval counter
        if (match) begin
            s_nxt.icnt = 8'h00;
            if (s_r.single_interval_select) begin
                s_nxt.interval_count_enable = 1'b0;
            end
        end else if (it_tick) begin
            s_nxt.icnt = s_r.icnt + 8'h01;
        end
        // Software writes override same-cycle counting
        if (sfr_wr_in) begin
            unique case (sfr_addr_in)
                `TIC_ADDR_CTRL: begin
                    s_nxt.twenty_four_hour_format = sfr_wdata_in[`TIC_BIT_TFH];
                    s_nxt.its = tic_pkg::timebase_t'({
                        sfr_wdata_in[`TIC_BIT_ITS_HI],
                        sfr_wdata_in[`TIC_BIT_ITS_LO]});
                    s_nxt.single_interval_select = sfr_wdata_in[`TIC_BIT_STI];
                    s_nxt.flag = sfr_wdata_in[`TIC_BIT_FLAG];
                    s_nxt.interval_count_enable = sfr_wdata_in[`TIC_BIT_INTERVAL_COUNT_ENABLE];
                    s_nxt.time_clock_enable = sfr_wdata_in[`TIC_BIT_TIME_CLOCK_ENABLE];
                end
                `TIC_ADDR_HTH: s_nxt.hth = sfr_wdata_in;
                `TIC_ADDR_SS: s_nxt.ss = sfr_wdata_in;
                `TIC_ADDR_MM: s_nxt.mm = sfr_wdata_in;
                `TIC_ADDR_HH: s_nxt.hh = sfr_wdata_in;
                `TIC_ADDR_IVAL: s_nxt.ival = sfr_wdata_in;
                default: ;
            endcase
        end
        // Disabled counter holds zero
        if (!s_nxt.interval_count_enable) begin
            s_nxt.icnt = 8'h00;
        end
        // Hardware set wins over a same-cycle clear
        if (match) begin
            s_nxt.flag = 1'b1;
        end
        s_nxt.irq = s_nxt.flag & irq_enable_in;
        // Read data mux, unmapped reads zero
        unique case (sfr_addr_in)
            `TIC_ADDR_CTRL: s_nxt.rdata = {1'b0, s_r.twenty_four_hour_format, s_r.its,
                s_r.single_interval_select, s_r.flag, s_r.interval_count_enable, s_r.time_clock_enable};
            `TIC_ADDR_HTH: s_nxt.rdata = s_r.hth;
            `TIC_ADDR_SS: s_nxt.rdata = s_r.ss;
            `TIC_ADDR_MM: s_nxt.rdata = s_r.mm;
            `TIC_ADDR_HH: s_nxt.rdata = s_r.hh;
            `TIC_ADDR_IVAL: s_nxt.rdata = s_r.ival;
            default: s_nxt.rdata = 8'h00;
        endcase
    end

    // State register
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flops
    assign sfr_rdata_out = s_r.rdata;
    assign interval_irq_out = s_r.irq;
    assign interval_match_flag_out = s_r.flag;

    // Checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    // Match sets the flag
    chk_match_flag: assert property (
        match |=> s_r.flag)
        else $error("match did not set flag");

    // Flag holds without a software clear
    chk_flag_sticky: assert property (
        s_r.flag && !(ctrl_wr && !sfr_wdata_in[`TIC_BIT_FLAG])
        |=> s_r.flag)
        else $error("flag dropped on its own");

    // Tick advances interval count by one
    chk_count_step: assert property (
        it_tick && !match && !ctrl_wr
        |=> s_r.icnt == $past(s_r.icnt) + 8'h01)
        else $error("interval count did not step");

    // Disable write clears the counter
    chk_disable_zero: assert property (
        ctrl_wr && !sfr_wdata_in[`TIC_BIT_INTERVAL_COUNT_ENABLE]
        |=> !s_r.interval_count_enable && s_r.icnt == 8'h00)
        else $error("disable did not clear counter");

    // Stopped clock freezes counters
    chk_clock_gate: assert property (
        !s_r.time_clock_enable && !sfr_wr_in
        |=> $stable(s_r.hth) && $stable(s_r.ss) && $stable(s_r.icnt))
        else $error("counter moved with clock off");

    // Seconds timebase only steps on seconds carry
    chk_sec_base: assert property (
        s_r.its == tic_pkg::TB_SEC && !ev_sec && !sfr_wr_in
        |=> $stable(s_r.icnt))
        else $error("seconds timebase stepped early");

    // Single mode stops after a match
    chk_single_stop: assert property (
        match && s_r.single_interval_select && !sfr_wr_in
        |=> !s_r.interval_count_enable ##1 s_r.icnt == 8'h00)
        else $error("single interval did not stop");

    // Repeat mode reloads and keeps running
    chk_reload: assert property (
        match && !s_r.single_interval_select && !sfr_wr_in
        |=> s_r.interval_count_enable && s_r.icnt == 8'h00)
        else $error("repeat interval did not reload");

    // Interrupt follows flag and enable
    chk_irq_follow: assert property (
        interval_irq_out == (s_r.flag && $past(irq_enable_in)))
        else $error("irq does not follow flag");

    // Sub-second wrap carries to seconds
    chk_sub_wrap: assert property (
        ev_sec && !sfr_wr_in
        |=> s_r.hth == 8'h00 && s_r.ss != $past(s_r.ss))
        else $error("sub-second wrap failed");

    // Seconds wrap carries to minutes
    chk_sec_wrap: assert property (
        ev_min && !sfr_wr_in
        |=> s_r.ss == 8'h00 && s_r.mm != $past(s_r.mm))
        else $error("seconds wrap failed");

    // Minutes wrap carries to hours
    chk_min_wrap: assert property (
        ev_hr && !sfr_wr_in
        |=> s_r.mm == 8'h00 && s_r.hh != $past(s_r.hh))
        else $error("minutes wrap failed");

    // 24-hour rollover at 23
    chk_hour_24: assert property (
        ev_hr && s_r.twenty_four_hour_format && s_r.hh == 8'h17 && !sfr_wr_in
        |=> s_r.hh == 8'h00)
        else $error("24-hour rollover failed");

    // Full range passes 23
    chk_hour_full: assert property (
        ev_hr && !s_r.twenty_four_hour_format && s_r.hh == 8'h17 && !sfr_wr_in
        |=> s_r.hh == 8'h18)
        else $error("full-range hour wrapped early");

    // Registers held at zero in reset
    chk_reset_zero: assert property (
        @(posedge clock_in) disable iff (1'b0)
        rst_in |-> s_r.ival == 8'h00 && s_r.hth == 8'h00
            && s_r.ss == 8'h00 && s_r.mm == 8'h00 && s_r.hh == 8'h00)
        else $error("registers not zero in reset");

    // Sub-second tick is a single-cycle pulse
    chk_tick_pulse: assert property (
        presc_tick && TICK_CYCLES > 1 |=> !presc_tick)
        else $error("tick wider than one cycle");

    // Main scenarios
    cov_single: cover property (match && s_r.single_interval_select);
    cov_repeat: cover property (match && !s_r.single_interval_select ##1 s_r.interval_count_enable);
    cov_hour_wrap: cover property (ev_hr && s_r.twenty_four_hour_format);
    cov_irq: cover property ($rose(interval_irq_out));
endmodule
`default_nettype wire

// [tb/time_interval_counter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module time_interval_counter_tb;
    localparam int T = 4; // Short tick period
    logic clock_in = 1'b0; // System clock
    logic rst_in = 1'b0; // Reset, raised just after start
    logic [7:0] addr = 8'h00; // Register address
    logic wr = 1'b0; // Write strobe
    logic [7:0] wd = 8'h00; // Write data
    logic ien = 1'b0; // Interrupt enable
    logic [7:0] rdata; // Read data
    logic irq; // Interrupt request
    logic flag; // Match flag
    // Model state
    int hth, ss, mm, hh, iv, ic, its, ph;
    bit twenty_four_hour_format, single_interval_select, fl, interval_count_enable, time_clock_enable, syn, chk;
    bit tk, g, c1, c2, c3, it, hs;
    logic [7:0] m_rd = 8'h00; // Expected read data
    bit m_fl, m_irq; // Expected flag and request
    int seed = 20476; // Random seed
    int n_mismatch = 0;
    int n_compared = 0;

    time_interval_counter #(.TICK_CYCLES(T)) i_time_interval_counter (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .sfr_addr_in(addr),
        .sfr_wr_in(wr),
        .sfr_wdata_in(wd),
        .irq_enable_in(ien),
        .sfr_rdata_out(rdata),
        .interval_irq_out(irq),
        .interval_match_flag_out(flag)
    );

    // Clock generator
    always #2 clock_in = ~clock_in;

    // Reference model, one step per clock edge
    always @(posedge clock_in) begin
        if (!rst_in) begin
            // Read data reflects state before the edge
            case (addr)
                8'ha1: m_rd = {1'b0, twenty_four_hour_format, its[1:0], single_interval_select, fl, interval_count_enable, time_clock_enable};
                8'ha2: m_rd = 8'(hth);
                8'ha3: m_rd = 8'(ss);
                8'ha4: m_rd = 8'(mm);
                8'ha5: m_rd = 8'(hh);
                8'ha6: m_rd = 8'(iv);
                default: m_rd = 8'h00;
            endcase
            tk = syn && ph == T - 1;
            ph = tk ? 0 : ph + 1;
            g = tk && time_clock_enable;
            c1 = g && hth == 127;
            c2 = c1 && ss == 59;
            c3 = c2 && mm == 59;
            if (g) hth = c1 ? 0 : hth + 1;
            if (c1) ss = c2 ? 0 : ss + 1;
            if (c2) mm = c3 ? 0 : mm + 1;
            if (c3) hh = (hh == (twenty_four_hour_format ? 23 : 255)) ? 0 : hh + 1;
            it = its == 0 ? g : its == 1 ? c1 : its == 2 ? c2 : c3;
            hs = it && interval_count_enable && ic == iv;
            if (it && interval_count_enable) ic = hs ? 0 : ic + 1;
            if (hs && single_interval_select) interval_count_enable = 0;
            // Software writes win over increments
            if (wr) begin
                case (addr)
                    8'ha1: begin
                        {twenty_four_hour_format, single_interval_select, fl, interval_count_enable, time_clock_enable} = {wd[6], wd[3:0]};
                        its = wd[5:4];
                    end
                    8'ha2: hth = wd;
                    8'ha3: ss = wd;
                    8'ha4: mm = wd;
                    8'ha5: hh = wd;
                    8'ha6: iv = wd;
                    default: ;
                endcase
            end
            fl = fl || hs;
            if (!interval_count_enable) ic = 0;
            m_fl = fl;
            m_irq = fl && ien;
        end
    end

    // Compare one value and count it
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare every cycle once outputs have settled
    always @(negedge clock_in) begin
        if (chk) begin
            check(rdata, m_rd);
            check({6'h00, flag, irq}, {6'h00, m_fl, m_irq});
        end
    end

    // Advance one cycle, inputs change just after the edge
    task automatic step();
        @(posedge clock_in);
        #1;
    endtask

    // One register write cycle, strobe left high for a following write
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        step();
    endtask

    // Idle cycles with random reads and interrupt enable
    task automatic run(input int n);
        // Strobe left high by the last write drops here
        wr = 1'b0;
        repeat (n) begin
            addr = 8'ha0 | 8'($random(seed) & 7);
            ien = 1'($random(seed));
            step();
        end
    endtask

    // Print counts and verdict, then stop
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        // A real rising edge, so the asynchronous reset is seen
        #1;
        rst_in = 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        chk = 1;
        // Reset values, unmapped places included
        for (int a = 8'ha0; a < 8'ha8; a++) begin
            addr = 8'(a);
            step();
        end
        // Align the model with the prescaler phase
        chk = 0;
        wr_reg(8'ha1, 8'h01);
        wr = 1'b0;
        addr = 8'ha2;
        for (int i = 0; i < 4 * T && rdata !== 8'h01; i++) step();
        hth = 1;
        ph = 1;
        m_rd = 8'h01;
        syn = 1;
        chk = 1;
        // Repeating interval at the fastest timebase
        wr_reg(8'ha6, 8'h02);
        wr_reg(8'ha1, 8'h03);
        run(16 * T);
        wr_reg(8'ha1, 8'h03);
        run(8 * T);
        // Single interval stops after one match
        wr_reg(8'ha1, 8'h0b);
        run(12 * T);
        // Disable clears the counter, clock gate stops all
        wr_reg(8'ha1, 8'h03);
        run(2 * T);
        wr_reg(8'ha1, 8'h01);
        wr_reg(8'ha1, 8'h03);
        run(6 * T);
        wr_reg(8'ha1, 8'h02);
        run(8 * T);
        // Every timebase, with full carry chains and both hour ranges
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'ha1, 8'h00);
            wr_reg(8'ha2, 8'h7f);
            wr_reg(8'ha3, 8'h3b);
            wr_reg(8'ha4, 8'h3b);
            wr_reg(8'ha5, (s[0] || !s[1]) ? 8'h17 : 8'hff);
            wr_reg(8'ha6, 8'h00);
            wr_reg(8'ha1, {1'b0, s[0], s[1:0], 4'h3});
            run(6 * T);
        end
        // Random compare values and control, single mode kept off
        wr_reg(8'ha1, 8'h00);
        repeat (40) begin
            wr_reg(8'ha6, 8'($random(seed) & 7));
            wr_reg(8'ha1, 8'($random(seed)) & 8'h77);
            run(3 * T);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
